//--- hdl/plam_pkg.sv
// constants and types for the latched-address pin mux
// assumes a single clock domain and a synchronous processor bus sampled on clk
package plam_pkg;
  // pin counts per port
  localparam int PLAM_PA_W = 8;
  localparam int PLAM_PB_W = 8;
  localparam int PLAM_PC_W = 8;
  localparam int PLAM_PD_W = 3;
  localparam int PLAM_PIN_N = 27;
  localparam int PLAM_ADDR_W = 16;
  localparam int PLAM_WIN_W = 8; // 256-byte register window
  // Port C test port pin positions
  localparam int PLAM_TP_MODE = 0;
  localparam int PLAM_TP_CLK = 1;
  localparam int PLAM_TP_STAT = 3;
  localparam int PLAM_TP_ERR = 4;
  localparam int PLAM_TP_DIN = 5;
  localparam int PLAM_TP_DOUT = 6;
  // Port D strobe pin
  localparam int PLAM_PD_STROBE = 0;
  // pin function encoding
  typedef enum logic [1:0] {
    PLAM_FN_MCU = 2'h0,
    PLAM_FN_PLD = 2'h1,
    PLAM_FN_ADDR = 2'h2,
    PLAM_FN_BUS = 2'h3
  } plam_fn_t;
  // processor bus style
  typedef enum logic [1:0] {
    PLAM_BUS_MUX8 = 2'h0,
    PLAM_BUS_NONMUX = 2'h1,
    PLAM_BUS_SPLIT = 2'h2,
    PLAM_BUS_PAGE = 2'h3
  } plam_bus_t;
  localparam logic [7:0] PLAM_ZERO8 = 8'h00;
endpackage : plam_pkg

//--- hdl/plam_addr_latch.sv
// address latch driven by the processor's address strobe
// assumes strobe and address synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module plam_addr_latch #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // processor side
  input wire logic strobeEn,
  input wire logic addressLatchStrobe,
  input wire logic [ADDR_W-1:0] busAddr,
  // latched result
  output logic [ADDR_W-1:0] latchedAddr
);
  logic [ADDR_W-1:0] latch_q;
  logic [ADDR_W-1:0] latch_d;
  // capture address while strobe high, hold after
  always_comb begin
    latch_d = latch_q;
    if (strobeEn && addressLatchStrobe) begin
      latch_d = busAddr;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_q <= '0;
    end else begin
      latch_q <= latch_d;
    end
  end
  assign latchedAddr = latch_q;
endmodule : plam_addr_latch
`default_nettype wire

//--- hdl/plam_port_mux.sv
// pin function multiplexer for ports A-D with latched address output
// assumes configuration inputs static or synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module plam_port_mux
  import plam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // per-pin function selects, two bits per pin, A..D packed
  input wire logic [2*plam_pkg::PLAM_PIN_N-1:0] pinFunc,
  input wire plam_pkg::plam_bus_t busStyle,
  input wire logic testPortEn,
  // processor bus
  input wire logic [plam_pkg::PLAM_ADDR_W-1:0] busAddr,
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe,
  input wire logic [plam_pkg::PLAM_ADDR_W-1:0] windowBase,
  output logic registerWindowSelect,
  output logic [plam_pkg::PLAM_WIN_W-1:0] registerOffset,
  // processor I/O and logic sources per pin
  input wire logic [plam_pkg::PLAM_PIN_N-1:0] mcuOut,
  input wire logic [plam_pkg::PLAM_PIN_N-1:0] mcuOe,
  input wire logic [plam_pkg::PLAM_PIN_N-1:0] pldOut,
  input wire logic [plam_pkg::PLAM_PIN_N-1:0] pldOe,
  // test port internal side
  input wire logic testPortStatusOut,
  input wire logic testPortErrorOut,
  input wire logic testPortDataOut,
  output logic testModeSel,
  output logic testClk,
  output logic testDataIn,
  // pins: input, output, enable
  input wire logic [plam_pkg::PLAM_PIN_N-1:0] pinIn,
  output logic [plam_pkg::PLAM_PIN_N-1:0] pinOut,
  output logic [plam_pkg::PLAM_PIN_N-1:0] pinOe,
  // pin values toward processor and logic
  output logic [plam_pkg::PLAM_PIN_N-1:0] pinInReg
);
  // first pin of each port in the packed pin vectors
  localparam int PB0 = PLAM_PA_W;
  localparam int PC0 = PLAM_PA_W + PLAM_PB_W;
  localparam int PD0 = PC0 + PLAM_PC_W;

  // latched address and its placement on the pins
  logic [PLAM_ADDR_W-1:0] latchedAddr;
  logic [PLAM_PIN_N-1:0] addrVal;
  logic [PLAM_PIN_N-1:0] addrOk;
  logic strobeEn;
  // pin drive and input sampling state
  logic [PLAM_PIN_N-1:0] out_d;
  logic [PLAM_PIN_N-1:0] out_q;
  logic [PLAM_PIN_N-1:0] oe_d;
  logic [PLAM_PIN_N-1:0] oe_q;
  logic [PLAM_PIN_N-1:0] in_d;
  logic [PLAM_PIN_N-1:0] in_q;
  // register window decode state
  logic sel_d;
  logic sel_q;
  logic [PLAM_WIN_W-1:0] off_d;
  logic [PLAM_WIN_W-1:0] off_q;
  // test port input state
  logic tms_d;
  logic tms_q;
  logic tck_d;
  logic tck_q;
  logic tdi_d;
  logic tdi_q;

  // function code of one pin
  function automatic plam_fn_t fnOf(input int idx);
    fnOf = plam_fn_t'(pinFunc[2*idx +: 2]);
  endfunction : fnOf

  // strobe use and sampled pin inputs; fnOf reads pinFunc, so its
  // callers sit in processes that re-run when any pin function changes
  always_comb begin
    strobeEn = fnOf(PD0 + PLAM_PD_STROBE) == PLAM_FN_BUS;
    in_d = pinIn;
    // test port inputs read as low while the port is off
    tms_d = testPortEn & pinIn[PC0 + PLAM_TP_MODE];
    tck_d = testPortEn & pinIn[PC0 + PLAM_TP_CLK];
    tdi_d = testPortEn & pinIn[PC0 + PLAM_TP_DIN];
  end

  // address latch on Port D bit 0 strobe
  plam_addr_latch #(.ADDR_W(PLAM_ADDR_W)) uLatch (
    .clk(clk),
    .sys_rst(sys_rst),
    .strobeEn(strobeEn),
    .addressLatchStrobe(pinIn[PD0 + PLAM_PD_STROBE]),
    .busAddr(busAddr),
    .latchedAddr(latchedAddr)
  );

  // nibble placement of latched address per bus style
  always_comb begin
    addrVal = '0;
    addrOk = '0;
    case (busStyle)
      PLAM_BUS_MUX8: begin
        // a7-a0 on both ports
        addrVal[PB0-1:0] = latchedAddr[7:0];
        addrOk[PB0-1:0] = '1;
        addrVal[PC0-1:PB0] = latchedAddr[7:0];
        addrOk[PC0-1:PB0] = '1;
      end
      PLAM_BUS_NONMUX: begin
        // Port B only, Port A is the data port
        addrVal[PC0-1:PB0] = latchedAddr[7:0];
        addrOk[PC0-1:PB0] = '1;
      end
      PLAM_BUS_SPLIT: begin
        // a7-a4 on A high, a11-a8 on B low
        addrVal[7:4] = latchedAddr[7:4];
        addrOk[7:4] = '1;
        addrVal[PB0+3:PB0] = latchedAddr[11:8];
        addrOk[PB0+3:PB0] = '1;
      end
      PLAM_BUS_PAGE: begin
        // a11-a8 on B low, a15-a12 on B high
        addrVal[PC0-1:PB0] = latchedAddr[15:8];
        addrOk[PC0-1:PB0] = '1;
      end
      default: begin
        addrVal = '0;
        addrOk = '0;
      end
    endcase
  end

  // per-pin output selection
  always_comb begin
    out_d = '0;
    oe_d = '0;
    for (int i = 0; i < PLAM_PIN_N; i++) begin
      case (fnOf(i))
        PLAM_FN_MCU: begin
          out_d[i] = mcuOut[i];
          oe_d[i] = mcuOe[i];
        end
        PLAM_FN_PLD: begin
          out_d[i] = pldOut[i];
          oe_d[i] = pldOe[i];
        end
        PLAM_FN_ADDR: begin
          out_d[i] = addrVal[i];
          oe_d[i] = addrOk[i];
        end
        PLAM_FN_BUS: begin
          // Port A carries bus data in all but the 8-bit mux style, Port B the high address byte in split style, Port D strobe is input
          // unsupported combinations leave the pin released
          if (i < PB0 && busStyle != PLAM_BUS_MUX8) begin
            out_d[i] = busDataOut[i];
            oe_d[i] = busDataOe;
          end else if (i >= PB0 && i < PC0 && busStyle == PLAM_BUS_SPLIT) begin
            out_d[i] = busAddr[i];
            oe_d[i] = busDataOe;
          end
        end
        default: begin
          out_d[i] = 1'b0;
          oe_d[i] = 1'b0;
        end
      endcase
    end
    if (testPortEn) begin
      // test port pins override the pin functions
      // input pins released so the outside probe can drive them
      oe_d[PC0 + PLAM_TP_MODE] = 1'b0;
      oe_d[PC0 + PLAM_TP_CLK] = 1'b0;
      oe_d[PC0 + PLAM_TP_DIN] = 1'b0;
      out_d[PC0 + PLAM_TP_STAT] = testPortStatusOut;
      oe_d[PC0 + PLAM_TP_STAT] = 1'b1;
      out_d[PC0 + PLAM_TP_ERR] = testPortErrorOut;
      oe_d[PC0 + PLAM_TP_ERR] = 1'b1;
      out_d[PC0 + PLAM_TP_DOUT] = testPortDataOut;
      oe_d[PC0 + PLAM_TP_DOUT] = 1'b1;
    end
  end

  // register window decode
  // only the upper byte is compared; the lower byte is the offset
  always_comb begin
    sel_d = busAddr[PLAM_ADDR_W-1:PLAM_WIN_W] ==
            windowBase[PLAM_ADDR_W-1:PLAM_WIN_W];
    off_d = busAddr[PLAM_WIN_W-1:0];
  end

  // output registers
  // every top output leaves one of these flip-flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= '0;
      oe_q <= '0;
      in_q <= '0;
      sel_q <= 1'b0;
      off_q <= PLAM_ZERO8;
      tms_q <= 1'b0;
      tck_q <= 1'b0;
      tdi_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      in_q <= in_d;
      sel_q <= sel_d;
      off_q <= off_d;
      tms_q <= tms_d;
      tck_q <= tck_d;
      tdi_q <= tdi_d;
    end
  end

  assign pinOut = out_q;
  assign pinOe = oe_q;
  assign pinInReg = in_q;
  assign registerWindowSelect = sel_q;
  assign registerOffset = off_q;
  assign testModeSel = tms_q;
  assign testClk = tck_q;
  assign testDataIn = tdi_q;
endmodule : plam_port_mux
`default_nettype wire

//--- tb/plam_mcu_model.sv
// processor bus model: address, data and latch strobe
// assumes the bench calls latch between clock edges
`timescale 1ns/10ps
`default_nettype none
module plam_mcu_model (
  // clock in, bus out
  input wire logic clk,
  output logic [15:0] busAddr,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  output logic addressLatchStrobe
);
  logic [7:0] data_q;
  logic [7:0] float_q;
  // idle bus; released data lines change every cycle
  initial {busAddr, data_q, float_q, busDataOe, addressLatchStrobe} = '0;
  always @(negedge clk) float_q <= ~float_q;
  assign busDataOut = busDataOe ? data_q : float_q;
  // drive or release the data lines from the next falling edge on
  task drive(input logic [7:0] d, input logic oe);
    @(negedge clk);
    data_q = d;
    busDataOe = oe;
  endtask : drive
  // one address phase, strobe high across one rising edge
  task latch(input logic [15:0] a);
    @(negedge clk);
    busAddr = a;
    addressLatchStrobe = 1'b1;
    @(negedge clk);
    addressLatchStrobe = 1'b0;
    busAddr = ~a; // no stale address after the phase
  endtask : latch
endmodule : plam_mcu_model
`default_nettype wire

//--- tb/plam_port_mux_checker.sv
// assertions on the port mux pins
// assumes bind into plam_port_mux, one clock
`timescale 1ns/10ps
`default_nettype none
module plam_port_mux_checker
  import plam_pkg::*;
(
  // watched top ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [53:0] pinFunc,
  input wire plam_pkg::plam_bus_t busStyle,
  input wire logic testPortEn,
  input wire logic [15:0] busAddr,
  input wire logic testPortStatusOut,
  input wire logic testPortErrorOut,
  input wire logic testClk,
  input wire logic [26:0] pinIn,
  input wire logic [26:0] pinOut,
  input wire logic [26:0] pinOe,
  input wire logic [26:0] pinInReg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // pin timing, test port takeover, latched address
  a_inreg_lag: assert property (
    !$past(sys_rst) |-> pinInReg == $past(pinIn)) else $error("pin input lag");
  a_test_stat: assert property (
    !$past(sys_rst) && $past(testPortEn) |-> pinOe[19] &&
    pinOut[19] == $past(testPortStatusOut)) else $error("status pin");
  a_test_err: assert property (
    !$past(sys_rst) && $past(testPortEn) |-> pinOe[20] &&
    pinOut[20] == $past(testPortErrorOut)) else $error("error pin");
  a_test_clk: assert property (
    !$past(sys_rst) && $past(testPortEn) |-> !pinOe[17] &&
    testClk == $past(pinIn[17])) else $error("test clock");
  a_test_inputs: assert property (
    !$past(sys_rst) && $past(testPortEn) |-> !pinOe[16] && !pinOe[21])
    else $error("test input driven");
  a_test_off: assert property (
    !$past(sys_rst) && !$past(testPortEn) |-> !testClk) else $error("clk off");
  a_addr_na: assert property (
    !$past(sys_rst) && $past(pinFunc[1:0]) == 2'h2 &&
    $past(busStyle) == PLAM_BUS_NONMUX |-> !pinOe[0]) else $error("n/a oe");
  a_addr_low: assert property (
    !$past(sys_rst) && pinIn[24] && pinFunc[49:48] == 2'h3 &&
    pinFunc[17:16] == 2'h2 && busStyle == PLAM_BUS_MUX8 ##1 !pinIn[24] &&
    $stable(pinFunc) && $stable(busStyle) |-> ##1 pinOe[8] &&
    pinOut[8] == $past(busAddr[0], 2)) else $error("latched address");
endmodule : plam_port_mux_checker
bind plam_port_mux plam_port_mux_checker i_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .pinFunc(pinFunc),
  .busStyle(busStyle),
  .testPortEn(testPortEn),
  .busAddr(busAddr),
  .testPortStatusOut(testPortStatusOut),
  .testPortErrorOut(testPortErrorOut),
  .testClk(testClk),
  .pinIn(pinIn),
  .pinOut(pinOut),
  .pinOe(pinOe),
  .pinInReg(pinInReg)
);
`default_nettype wire

//--- tb/plam_port_mux_tb.sv
// bench for the latched-address pin mux
// assumes the mux, its checker and plam_mcu_model
`timescale 1ns/10ps
`default_nettype none
module plam_port_mux_tb;
  import plam_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, testPortEn = 1'b0;
  logic testPortStatusOut = 1'b0, testPortErrorOut = 1'b0;
  logic testPortDataOut = 1'b0;
  logic [53:0] pinFunc = '0;
  plam_bus_t busStyle = PLAM_BUS_MUX8;
  logic [15:0] windowBase = 16'h0000, busAddr;
  logic [26:0] mcuOut = '0, mcuOe = '0, pldOut = '0, pldOe = '0;
  logic [26:0] pinDrv = 27'h0230000, pinIn, pinOut, pinOe, pinInReg;
  logic [7:0] busDataOut, registerOffset;
  logic busDataOe, addressLatchStrobe, registerWindowSelect;
  logic testModeSel, testClk, testDataIn;
  int n_errors = 0, num_checks = 0, cycles = 0;
  // strobe pin comes from the bus model
  assign pinIn = {pinDrv[26:25], addressLatchStrobe, pinDrv[23:0]};
  plam_mcu_model i_mcu (
    .clk(clk),
    .busAddr(busAddr),
    .busDataOut(busDataOut),
    .busDataOe(busDataOe),
    .addressLatchStrobe(addressLatchStrobe)
  );
  plam_port_mux i_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinFunc(pinFunc),
    .busStyle(busStyle),
    .testPortEn(testPortEn),
    .busAddr(busAddr),
    .busDataOut(busDataOut),
    .busDataOe(busDataOe),
    .windowBase(windowBase),
    .registerWindowSelect(registerWindowSelect),
    .registerOffset(registerOffset),
    .mcuOut(mcuOut),
    .mcuOe(mcuOe),
    .pldOut(pldOut),
    .pldOe(pldOe),
    .testPortStatusOut(testPortStatusOut),
    .testPortErrorOut(testPortErrorOut),
    .testPortDataOut(testPortDataOut),
    .testModeSel(testModeSel),
    .testClk(testClk),
    .testDataIn(testDataIn),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .pinInReg(pinInReg)
  );
  // clock and hang guard
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      results();
    end
  end
  // counted compare
  task chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // latch one address under each bus style
  task t_addr;
    logic [15:0] eo [4] = '{16'hFFFF, 16'hFF00, 16'h0FF0, 16'hFF00};
    logic [15:0] ev [4] = '{16'hA3A3, 16'hA300, 16'h05A0, 16'hC500};
    pinFunc = {4'h0, 2'h3, 16'h0, 32'hAAAAAAAA};
    {mcuOut, mcuOe} = {27'h5A5A5A5, 27'h7FFFFFF};
    for (int s = 0; s < 4; s++) begin
      busStyle = plam_bus_t'(s);
      windowBase = s[0] ? 16'hC600 : 16'hC5FF;
      i_mcu.latch(16'hC5A3);
      chk("windowSel", 16'(registerWindowSelect), 16'(!s[0]));
      chk("offset", 16'(registerOffset), 16'h00A3);
      repeat (2) @(negedge clk);
      chk("addrOe", pinOe[15:0], eo[s]);
      chk("addrOut", pinOut[15:0] & eo[s], ev[s]);
    end
    chk("mcuOut", 16'(pinOut[23:16]), 16'h00A5);
    $display("address latch test done");
  endtask : t_addr
  // test port over logic outputs, on then off
  task t_test;
    pinFunc = {27{2'h1}};
    {pldOut, pldOe} = {27'h2D2D2D2, 27'h7FFFFFF};
    {testPortStatusOut, testPortErrorOut, testPortDataOut} = 3'h7;
    for (int e = 1; e >= 0; e--) begin
      testPortEn = e[0];
      repeat (3) @(negedge clk);
      chk("pldOut", pinOut[15:0], 16'hD2D2);
      chk("tOe", 16'(pinOe[23:16]), e ? 16'h00DC : 16'h00FF);
      chk("tOut", 16'(pinOut[23:16] & 8'h5C), e ? 16'h58 : 16'h50);
      chk("tIn", 16'({testModeSel, testClk, testDataIn}), 16'(e * 7));
    end
    $display("test port test done");
  endtask : t_test
  // bus function on ports A/B under each style, then released
  task t_bus;
    logic [15:0] eo [4] = '{16'h0000, 16'h00FF, 16'hFFFF, 16'h00FF};
    logic [15:0] ev [4] = '{16'h0000, 16'h0096, 16'h3A96, 16'h0096};
    pinFunc = {22'h0, 32'hFFFFFFFF};
    i_mcu.latch(16'hC5A3); // leaves busAddr at 16'h3A5C
    for (int s = 0; s < 4; s++) begin
      busStyle = plam_bus_t'(s);
      i_mcu.drive(8'h96, 1'b1);
      repeat (2) @(negedge clk);
      chk("busOe", pinOe[15:0], eo[s]);
      chk("busOut", pinOut[15:0] & eo[s], ev[s]);
    end
    i_mcu.drive(8'h96, 1'b0);
    repeat (2) @(negedge clk);
    chk("busOff", pinOe[15:0], 16'h0000);
    chk("inReg", 16'(pinInReg[23:16]), 16'h0023);
    $display("bus function test done");
  endtask : t_bus
  // verdict and end of run
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // reset, then the scenarios
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    t_addr();
    t_test();
    t_bus();
    results();
  end
endmodule : plam_port_mux_tb
`default_nettype wire
